/* File: verilog/rrh_pkg.sv */
// Shared constants and types for the remote register handshake
package rrh_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam int CMD_W = 16;
	localparam int DATA_W = 32;
	localparam int HIST_DEPTH = 10;
	localparam int ALARM_W = 8;

	// ----------------------------------------
	// Codes and field positions
	// ----------------------------------------
	localparam logic [CMD_W-1:0] CMD_IDLE = 16'h0000;
	localparam int ADDR_UNPOWERED_BIT = 15;
	localparam logic [7:0] FAULT_CLEAR_CODE = 8'h06;
	// Command classes taken from the top nibble of the command code
	localparam logic [3:0] CLS_READ = 4'h1;
	localparam logic [3:0] CLS_WRITE = 4'h2;
	localparam logic [3:0] CLS_MAINT = 4'h3;
	localparam logic [3:0] CLS_MONITOR = 4'h4;
	localparam logic [3:0] CLS_HISTORY = 4'h5;
	localparam logic [3:0] CLS_HIST_CLEAR = 4'h6;
	localparam logic [3:0] CLS_FAULT_CLEAR = 4'h7;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_NS = 100;
	localparam int MASTER_CYCLE_NS = 500;
	localparam int SERIAL_CYCLE_NS = 800;
	localparam int MASTER_CYCLES = (MASTER_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SERIAL_CYCLES = (SERIAL_CYCLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int LATENCY_CYCLES = MASTER_CYCLES + SERIAL_CYCLES;
	localparam int LAT_W = 8;
	localparam int BLINK_CYCLES = 4;
	localparam logic [DATA_W-1:0] RANGE_MAX = 32'h0000FFFF;
	localparam logic [DATA_W-1:0] RESET_DATA = 32'h00000000;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_BUSY,
		DEV_DONE
	} dev_state_t;

	typedef enum logic [1:0] {
		HOST_IDLE,
		HOST_WAIT_ECHO,
		HOST_WAIT_DONE,
		HOST_WAIT_DROP
	} host_state_t;

	// Classifies a command code by its top nibble
	function automatic logic [3:0] cmd_class(input logic [CMD_W-1:0] c);
		cmd_class = c[CMD_W-1 -: 4];
	endfunction
endpackage

/* File: verilog/rrh_if.sv */
// Link between the fieldbus master and the gateway
interface rrh_if;
	import rrh_pkg::*;
	logic connected;
	logic [ADDR_W-1:0] reg_addr;
	logic [CMD_W-1:0] cmd_code;
	logic [DATA_W-1:0] data;
	logic request_strobe;
	logic fault_clear_command;
	logic [ADDR_W-1:0] reg_addr_echo;
	logic [CMD_W-1:0] cmd_echo;
	logic [DATA_W-1:0] data_echo;
	logic request_echo_strobe;
	logic error_status;
	logic link_fault_flag;

	modport gateway(
		input reg_addr, cmd_code, data, request_strobe, fault_clear_command,
		output connected, reg_addr_echo, cmd_echo, data_echo,
		output request_echo_strobe, error_status, link_fault_flag
	);
	modport master(
		output reg_addr, cmd_code, data, request_strobe, fault_clear_command,
		input connected, reg_addr_echo, cmd_echo, data_echo,
		input request_echo_strobe, error_status, link_fault_flag
	);
endinterface

/* File: verilog/rrh_gateway.sv */
// Gateway end of the remote register handshake
// How it works
// - master idles command and strobe when disconnected
// - echo address MSB set when product unpowered
// - master sets address, then raises strobe
// - echo strobe rises once operation completes
// - strobe fall ends transaction, echo falls
// - rising strobe writes data on write
// - rising strobe runs maintenance command
// - monitor data refreshes while strobe held
// - rejected written value raises error status
// - falling strobe clears error status
// - transfer fault also raises error status
// - unit alarm halts serial, blinks indicator
// - keep ten newest alarms, clearable
// - halted serial refuses parameter/maint/monitor
// - unit alarm cleared only by power cycle
// - link fault stops motor, serial continues
// - link fault lights error indicator
// - link fault cleared by tool, power, 06h
// - latency is master plus serial cycles
// - fault clear rising edge clears link fault
module rrh_gateway
	import rrh_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	rrh_if.gateway bus,
	input wire logic product_powered,
	input wire logic unit_alarm_event,
	input wire logic [ALARM_W-1:0] unit_alarm_code,
	input wire logic link_fault_event,
	input wire logic transfer_fault,
	input wire logic tool_alarm_reset,
	input wire logic [DATA_W-1:0] monitor_value,
	output logic serial_enable,
	output logic motor_enable,
	output logic alarm_indicator,
	output logic error_indicator,
	output logic maint_exec,
	output logic [CMD_W-1:0] maint_code
);
	// ----------------------------------------
	// Local state
	// ----------------------------------------
	dev_state_t state;
	logic strobe_q;
	logic fclr_q;
	logic unit_alarm;
	logic [LAT_W-1:0] lat_cnt;
	logic [CMD_W-1:0] cmd_q;
	logic [DATA_W-1:0] store [HIST_DEPTH];
	logic [ALARM_W-1:0] hist [HIST_DEPTH];
	logic [3:0] hist_count;
	logic [LAT_W-1:0] blink_cnt;
	logic strobe_rise;
	logic strobe_fall;
	logic fclr_rise;
	logic [3:0] cls;
	logic refused;
	logic [3:0] idx;

	assign strobe_rise = bus.request_strobe && !strobe_q;
	assign strobe_fall = !bus.request_strobe && strobe_q;
	assign fclr_rise = bus.fault_clear_command && !fclr_q;
	assign cls = cmd_class(cmd_q);
	assign idx = (bus.reg_addr[3:0] < 4'(HIST_DEPTH)) ? bus.reg_addr[3:0]
		: 4'h0;
	assign refused = unit_alarm && (cls == CLS_READ || cls == CLS_WRITE
		|| cls == CLS_MAINT || cls == CLS_MONITOR);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strobe_q <= 1'b0;
			fclr_q <= 1'b0;
		end else begin
			strobe_q <= bus.request_strobe;
			fclr_q <= bus.fault_clear_command;
		end
	end

	// ----------------------------------------
	// Connection and address echo
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus.connected <= 1'b0;
			bus.reg_addr_echo <= '0;
		end else begin
			bus.connected <= product_powered;
			bus.reg_addr_echo <= bus.reg_addr;
			bus.reg_addr_echo[ADDR_UNPOWERED_BIT] <= !product_powered;
		end
	end

	// ----------------------------------------
	// Handshake sequencer
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= DEV_IDLE;
			lat_cnt <= '0;
			cmd_q <= CMD_IDLE;
			bus.request_echo_strobe <= 1'b0;
			bus.cmd_echo <= CMD_IDLE;
			bus.data_echo <= RESET_DATA;
			maint_exec <= 1'b0;
			maint_code <= CMD_IDLE;
		end else begin
			maint_exec <= 1'b0;
			case (state)
				DEV_IDLE: begin
					if (strobe_rise) begin
						cmd_q <= bus.cmd_code;
						lat_cnt <= LAT_W'(LATENCY_CYCLES);
						state <= DEV_BUSY;
					end
				end
				DEV_BUSY: begin
					if (lat_cnt > LAT_W'(1)) begin
						lat_cnt <= lat_cnt - LAT_W'(1);
					end else begin
						bus.cmd_echo <= cmd_q;
						if (refused) begin
							bus.data_echo <= RESET_DATA;
						end else begin
							case (cls)
								CLS_READ: bus.data_echo <= store[idx];
								CLS_WRITE: bus.data_echo <= bus.data;
								CLS_MONITOR: bus.data_echo <= monitor_value;
								CLS_HISTORY: bus.data_echo <= (idx < hist_count)
									? DATA_W'(hist[idx]) : RESET_DATA;
								default: bus.data_echo <= bus.data;
							endcase
							if (cls == CLS_MAINT) begin
								maint_exec <= 1'b1;
								maint_code <= cmd_q;
							end
						end
						bus.request_echo_strobe <= 1'b1;
						state <= DEV_DONE;
					end
				end
				DEV_DONE: begin
					if (cls == CLS_MONITOR && !refused) begin
						bus.data_echo <= monitor_value;
					end
					if (!bus.request_strobe) begin
						bus.request_echo_strobe <= 1'b0;
						state <= DEV_IDLE;
					end
				end
				default: state <= DEV_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Parameter store
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				store[i] <= RESET_DATA;
			end
		end else if (state == DEV_BUSY && lat_cnt <= LAT_W'(1)
			&& cls == CLS_WRITE && !refused && bus.data <= RANGE_MAX) begin
			store[idx] <= bus.data;
		end
	end

	// ----------------------------------------
	// Error status
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus.error_status <= 1'b0;
		end else if (state == DEV_BUSY && lat_cnt <= LAT_W'(1)
			&& (refused || (cls == CLS_WRITE && bus.data > RANGE_MAX))) begin
			bus.error_status <= 1'b1;
		end else if (transfer_fault && state == DEV_BUSY) begin
			bus.error_status <= 1'b1;
		end else if (strobe_fall) begin
			bus.error_status <= 1'b0;
		end
	end

	// ----------------------------------------
	// Unit alarm and history
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			unit_alarm <= 1'b0;
			hist_count <= '0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist[i] <= '0;
			end
		end else begin
			if (unit_alarm_event) begin
				unit_alarm <= 1'b1;
			end
			if (unit_alarm_event) begin
				hist[0] <= unit_alarm_code;
				for (int i = 1; i < HIST_DEPTH; i++) begin
					hist[i] <= hist[i-1];
				end
				if (hist_count < 4'(HIST_DEPTH)) begin
					hist_count <= hist_count + 4'h1;
				end
			end else if (state == DEV_BUSY && lat_cnt <= LAT_W'(1)
				&& cls == CLS_HIST_CLEAR) begin
				hist_count <= '0;
				for (int i = 0; i < HIST_DEPTH; i++) begin
					hist[i] <= '0;
				end
			end
		end
	end

	// ----------------------------------------
	// Link fault and indicators
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bus.link_fault_flag <= 1'b0;
			serial_enable <= 1'b0;
			motor_enable <= 1'b0;
			alarm_indicator <= 1'b0;
			error_indicator <= 1'b0;
			blink_cnt <= '0;
		end else begin
			// Set wins over any clear
			if (link_fault_event) begin
				bus.link_fault_flag <= 1'b1;
			end else if (fclr_rise || tool_alarm_reset
				|| (state == DEV_BUSY && lat_cnt <= LAT_W'(1)
				&& cls == CLS_FAULT_CLEAR
				&& cmd_q[7:0] == FAULT_CLEAR_CODE)) begin
				bus.link_fault_flag <= 1'b0;
			end
			// serial halts only on unit alarm
			serial_enable <= !unit_alarm;
			motor_enable <= !bus.link_fault_flag && !unit_alarm;
			error_indicator <= bus.link_fault_flag;
			blink_cnt <= blink_cnt + LAT_W'(1);
			if (unit_alarm) begin
				alarm_indicator <= blink_cnt[BLINK_CYCLES-1];
			end else begin
				alarm_indicator <= bus.link_fault_flag;
			end
		end
	end
endmodule

/* File: verilog/rrh_master.sv */
// Master end of the remote register handshake
module rrh_master
	import rrh_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	rrh_if.master bus,
	input wire logic req_valid,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [CMD_W-1:0] req_cmd,
	input wire logic [DATA_W-1:0] req_data,
	input wire logic clear_fault,
	output logic req_ready,
	output logic resp_valid,
	output logic [CMD_W-1:0] resp_cmd,
	output logic [DATA_W-1:0] resp_data,
	output logic resp_error
);
	host_state_t state;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= HOST_IDLE;
			bus.reg_addr <= '0;
			bus.cmd_code <= CMD_IDLE;
			bus.data <= RESET_DATA;
			bus.request_strobe <= 1'b0;
			bus.fault_clear_command <= 1'b0;
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_cmd <= CMD_IDLE;
			resp_data <= RESET_DATA;
			resp_error <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			bus.fault_clear_command <= clear_fault;
			req_ready <= bus.connected && state == HOST_IDLE
				&& !bus.request_echo_strobe;
			if (!bus.connected) begin
				bus.cmd_code <= CMD_IDLE;
				bus.request_strobe <= 1'b0;
				state <= HOST_IDLE;
			end else begin
				case (state)
					HOST_IDLE: begin
						// wait for echo low before next
						if (req_valid && req_ready) begin
							bus.reg_addr <= req_addr;
							bus.cmd_code <= req_cmd;
							bus.data <= req_data;
							state <= HOST_WAIT_ECHO;
						end
					end
					HOST_WAIT_ECHO: begin
						if (bus.reg_addr_echo[ADDR_UNPOWERED_BIT-1:0]
							== bus.reg_addr[ADDR_UNPOWERED_BIT-1:0]) begin
							bus.request_strobe <= 1'b1;
							state <= HOST_WAIT_DONE;
						end
					end
					HOST_WAIT_DONE: begin
						if (bus.request_echo_strobe) begin
							resp_cmd <= bus.cmd_echo;
							resp_data <= bus.data_echo;
							resp_error <= bus.error_status;
							resp_valid <= 1'b1;
							bus.request_strobe <= 1'b0;
							state <= HOST_WAIT_DROP;
						end
					end
					HOST_WAIT_DROP: begin
						if (!bus.request_echo_strobe) begin
							bus.cmd_code <= CMD_IDLE;
							state <= HOST_IDLE;
						end
					end
					default: state <= HOST_IDLE;
				endcase
			end
		end
	end
endmodule

/* File: verif/rrh_link_sva.sv */
// Handshake checker on the link between master and gateway
module rrh_link_sva
	import rrh_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic connected,
	input wire logic [ADDR_W-1:0] reg_addr_echo,
	input wire logic [CMD_W-1:0] cmd_code,
	input wire logic request_strobe,
	input wire logic fault_clear_command,
	input wire logic request_echo_strobe,
	input wire logic error_status,
	input wire logic link_fault_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Handshake steps
	// ----------------------------------------
	sequence s_take;
		$rose(request_strobe) && !request_echo_strobe;
	endsequence
	sequence s_answer;
		!request_echo_strobe[*8] ##[1:10] request_echo_strobe;
	endsequence
	sequence s_drop;
		$fell(request_strobe);
	endsequence
	a_echo_after_work: assert property (s_take |-> s_answer)
		else $error("echo strobe outside its window");
	a_echo_falls: assert property (s_drop |-> ##[1:2] !request_echo_strobe)
		else $error("echo strobe stuck after strobe drop");
	a_echo_holds: assert property (
		request_echo_strobe && request_strobe |=> request_echo_strobe)
		else $error("echo strobe dropped early");
	a_no_echo_idle: assert property (
		!request_strobe && !request_echo_strobe |=> !request_echo_strobe)
		else $error("echo strobe without request");
	// Power loss marker tracks the connection state
	// Both sit at zero for the first edge after reset
	a_unpowered_msb: assert property (
		!$past(rst) |-> reg_addr_echo[ADDR_UNPOWERED_BIT] == !connected)
		else $error("address echo top bit wrong");
	a_idle_disconn: assert property (
		!connected [*2] |-> cmd_code == CMD_IDLE && !request_strobe)
		else $error("master active while disconnected");
	a_error_clears: assert property (s_drop |-> ##[1:2] !error_status)
		else $error("error status not cleared");
	a_error_in_txn: assert property (
		$rose(error_status) |-> request_strobe || request_echo_strobe)
		else $error("error status outside transaction");
	a_fault_clear: assert property (
		$rose(fault_clear_command) |-> ##[1:2] !link_fault_flag)
		else $error("link fault not cleared");
endmodule

/* File: verif/test_remote_register_handshake.sv */
// Self-checking bench for both ends of the handshake
module test_remote_register_handshake
	import rrh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {
		logic [CMD_W-1:0] c;
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] x;
		logic e;
	} row_t;
	logic mclk, rst, req_valid, clear_fault, product_powered;
	logic unit_alarm_event, link_fault_event, transfer_fault, tool_alarm_reset;
	logic [ADDR_W-1:0] req_addr;
	logic [CMD_W-1:0] req_cmd, resp_cmd, maint_code;
	logic [DATA_W-1:0] req_data, monitor_value, resp_data;
	logic [ALARM_W-1:0] unit_alarm_code;
	logic req_ready, resp_valid, resp_error, serial_enable, motor_enable;
	logic alarm_indicator, error_indicator, maint_exec, last_led;
	int err_total, compares, maint_cnt, flips;
	row_t rows[8];
	rrh_if link();
	rrh_master i_rrh_master(.mclk(mclk), .rst(rst), .bus(link),
		.req_valid(req_valid), .req_addr(req_addr), .req_cmd(req_cmd),
		.req_data(req_data), .clear_fault(clear_fault), .req_ready(req_ready),
		.resp_valid(resp_valid), .resp_cmd(resp_cmd), .resp_data(resp_data),
		.resp_error(resp_error));
	rrh_gateway i_rrh_gateway(.mclk(mclk), .rst(rst), .bus(link),
		.product_powered(product_powered), .unit_alarm_event(unit_alarm_event),
		.unit_alarm_code(unit_alarm_code), .link_fault_event(link_fault_event),
		.transfer_fault(transfer_fault), .tool_alarm_reset(tool_alarm_reset),
		.monitor_value(monitor_value), .serial_enable(serial_enable),
		.motor_enable(motor_enable), .alarm_indicator(alarm_indicator),
		.error_indicator(error_indicator), .maint_exec(maint_exec),
		.maint_code(maint_code));
	rrh_link_sva i_rrh_link_sva(.mclk(mclk), .rst(rst),
		.connected(link.connected), .reg_addr_echo(link.reg_addr_echo),
		.cmd_code(link.cmd_code), .request_strobe(link.request_strobe),
		.fault_clear_command(link.fault_clear_command),
		.request_echo_strobe(link.request_echo_strobe),
		.error_status(link.error_status),
		.link_fault_flag(link.link_fault_flag));
	always #50 mclk = ~mclk;
	always @(posedge mclk) begin
		if (maint_exec === 1'b1) maint_cnt++;
		if (alarm_indicator !== last_led) flips++;
		last_led = alarm_indicator;
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [DATA_W-1:0] seen, exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, what);
		end
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Strobes one event input: 0 link fault, 1 fault clear,
	// 2 tool reset, 3 unit alarm
	task pulse(input int which);
		link_fault_event <= (which == 0);
		clear_fault <= (which == 1);
		tool_alarm_reset <= (which == 2);
		unit_alarm_event <= (which == 3);
		@(posedge mclk);
		link_fault_event <= 1'b0;
		clear_fault <= 1'b0;
		tool_alarm_reset <= 1'b0;
		unit_alarm_event <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// Bounded waits: a hang ends the run as a mismatch
	task xfer(input logic [CMD_W-1:0] c, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int i;
		for (i = 0; i < 50 && req_ready !== 1'b1; i++) @(posedge mclk);
		if (i == 50) begin err_total++; final_report(); end
		req_valid <= 1'b1; req_cmd <= c; req_addr <= a; req_data <= d;
		@(posedge mclk);
		req_valid <= 1'b0;
		for (i = 0; i < 60 && resp_valid !== 1'b1; i++) @(posedge mclk);
		if (i == 60) begin err_total++; final_report(); end
		repeat (3) @(posedge mclk);
	endtask
	initial begin
		mclk = 0; rst = 1; req_valid = 0; clear_fault = 0; req_addr = 0;
		req_cmd = 0; req_data = 0; product_powered = 1; unit_alarm_event = 0;
		link_fault_event = 0; transfer_fault = 0; tool_alarm_reset = 0;
		unit_alarm_code = 8'hA5; monitor_value = 32'h12345678;
		rows = '{'{16'h2000, 16'h0000, 32'h000003E8, 32'h000003E8, 0},
			'{16'h1000, 16'h0000, 32'h0, 32'h000003E8, 0},
			'{16'h2009, 16'h0009, 32'h0000FFFF, 32'h0000FFFF, 0},
			'{16'h1009, 16'h0009, 32'h0, 32'h0000FFFF, 0},
			'{16'h2000, 16'h0000, 32'h00010000, 32'h0, 1},
			'{16'h1000, 16'h0000, 32'h0, 32'h000003E8, 0},
			'{16'h4000, 16'h0000, 32'h0, 32'h12345678, 0},
			'{16'h1001, 16'h0001, 32'h0, 32'h0, 0}};
		repeat (6) @(posedge mclk);
		chk(link.request_echo_strobe, 0, "echo in reset");
		chk(req_ready, 0, "ready in reset");
		rst <= 1'b0;
		foreach (rows[k]) begin
			xfer(rows[k].c, rows[k].a, rows[k].d);
			chk(resp_cmd, rows[k].c, "command echo");
			chk(resp_error, rows[k].e, "error flag");
			if (!rows[k].e) chk(resp_data, rows[k].x, "data echo");
			$display("row %0d done", k);
		end
		maint_cnt = 0;
		xfer(16'h3001, 16'h0000, 32'h0);
		chk(maint_cnt, 1, "maintenance pulses");
		chk(maint_code, 16'h3001, "maintenance code");
		transfer_fault <= 1'b1;
		xfer(16'h1000, 16'h0000, 32'h0);
		transfer_fault <= 1'b0;
		chk(resp_error, 1, "transfer fault");
		chk(link.error_status, 0, "error left set");
		$display("maintenance and fault test done");
		for (int k = 0; k < 3; k++) begin
			pulse(0);
			chk(link.link_fault_flag, 1, "link fault");
			chk(motor_enable, 0, "motor still on");
			chk(serial_enable, 1, "serial halted");
			chk(error_indicator, 1, "error lamp");
			chk(alarm_indicator, 1, "alarm lamp dark");
			if (k == 0) pulse(1);
			else if (k == 1) pulse(2);
			else xfer(16'h7006, 16'h0000, 32'h0);
			chk(link.link_fault_flag, 0, "link fault stays");
		end
		$display("link fault test done");
		product_powered <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(link.reg_addr_echo[ADDR_UNPOWERED_BIT], 1, "power marker");
		chk(link.cmd_code, CMD_IDLE, "command while off");
		product_powered <= 1'b1;
		$display("power test done");
		pulse(3);
		chk(serial_enable, 0, "serial runs in alarm");
		flips = 0;
		repeat (40) @(posedge mclk);
		chk(flips > 1, 1, "alarm lamp still");
		xfer(16'h1000, 16'h0000, 32'h0);
		chk(resp_error, 1, "refusal flag");
		chk(resp_data, 0, "refused data");
		xfer(16'h5000, 16'h0000, 32'h0);
		chk(resp_data, 32'h000000A5, "newest alarm");
		xfer(16'h6000, 16'h0000, 32'h0);
		xfer(16'h5000, 16'h0000, 32'h0);
		chk(resp_data, 0, "history cleared");
		pulse(2);
		chk(serial_enable, 0, "alarm cleared by tool");
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(serial_enable, 1, "alarm kept over reset");
		$display("unit alarm test done");
		final_report();
	end
endmodule
